/* rtl/dma_defs.svh */
// Register offsets, field positions, reset values and command codes
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_TIMING 8'h04
`define OFS_START_A 8'h08
`define OFS_START_B 8'h0C
`define OFS_BLOCK_LEN 8'h10
`define OFS_MATCH 8'h14
`define OFS_ADDR_MODE 8'h18
`define OFS_INT_EN 8'h1C
`define OFS_VECTOR 8'h20
`define OFS_PULSE_OFS 8'h24
`define OFS_COMMAND 8'h28
`define OFS_STATUS 8'h30
`define OFS_COUNT 8'h34
`define OFS_CUR_A 8'h38
`define OFS_CUR_B 8'h3C
`define OFS_CUR_VEC 8'h40

// ==========================================================
// Control register fields
`define CTRL_CLASS_LO 0
`define CTRL_MODE_LO 2
`define CTRL_A_IS_SRC 4
`define CTRL_AUTO_RST 5
`define CTRL_RDY_HIGH 6
`define CTRL_WAIT_EN 7
`define CTRL_PULSE_EN 8
`define CTRL_VEC_MOD 9
`define CTRL_A_IS_IO 10
`define CTRL_B_IS_IO 11
`define CTRL_RESET 12'h010

// Interrupt enable bits
`define IEN_READY 0
`define IEN_MATCH 1
`define IEN_EOB 2
`define IEN_MATCH_EOB 3

// ==========================================================
// Command codes
`define CMD_ENABLE 8'h87
`define CMD_DISABLE 8'h83
`define CMD_LOAD 8'hCF
`define CMD_CONTINUE 8'hD3
`define CMD_CLR_STATUS 8'hB3
`define CMD_READ_STATUS 8'hBF
`define CMD_INIT_READ 8'hA7

// ==========================================================
// Timing: clocks per T-cycle, so half a T-cycle is one clock
`define CLK_PER_T 2
`define VECTOR_RESET 8'h00

`endif

/* rtl/dma_pkg.sv */
// Types shared by the engine modules
package dma_pkg;
  typedef enum logic [1:0] {CLS_TRANSFER, CLS_SEARCH, CLS_BOTH} op_class_t;
  typedef enum logic [1:0] {MODE_BYTE, MODE_BURST, MODE_CONT} op_mode_t;
  typedef enum logic [1:0] {ADR_FIXED, ADR_INC, ADR_DEC} addr_rule_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_READ, ST_WRITE, ST_NEXT, ST_PAUSE, ST_RELEASE
  } state_t;
endpackage

/* rtl/byte_match.sv */
// Masked comparison of a data byte against the match byte
`timescale 1ns/10ps
module byte_match #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data,
  input wire logic [WIDTH-1:0] match,
  input wire logic [WIDTH-1:0] mask,
  output logic hit
);
  // A set mask bit excludes that position from the compare
  assign hit = ~|((data ^ match) & ~mask);
endmodule

/* rtl/dma_engine.sv */
// Single-channel transfer and search engine with Wishbone registers
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "dma_defs.svh"
module dma_engine import dma_pkg::*; #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_request_in,
  output logic bus_request_out,
  output logic bus_request_oe_n,
  input wire logic bus_grant_in_n,
  input wire logic ready_in,
  input wire logic chip_select_wait_n,
  input wire logic int_ack_n,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe_n,
  output logic [AW-1:0] addr_out,
  output logic addr_oe_n,
  output logic io_request_strobe_n,
  output logic memory_request_strobe_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic interrupt_pulse_out,
  output logic interrupt_pulse_oe_n
);

  // ==========================================================
  // Input synchronisers
  localparam int SW = DW + 5;
  logic [SW-1:0] sync1_reg, sync2_reg;
  // Pins are asynchronous to clk, two flops before use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= {bus_request_in, bus_grant_in_n, ready_in,
                    chip_select_wait_n, int_ack_n, data_in};
      sync2_reg <= sync1_reg;
    end
  end
  logic bus_request_line_s, grant_n_s, ready_s, wait_n_s, intack_n_s;
  logic [DW-1:0] data_s;
  assign {bus_request_line_s, grant_n_s, ready_s, wait_n_s, intack_n_s, data_s} =
         sync2_reg;

  // ==========================================================
  // Registers and state
  logic [11:0] ctrl_reg, timing_reg;
  logic [AW-1:0] start_a_reg, start_b_reg, cur_a_reg, cur_b_reg;
  logic [15:0] block_len_reg, count_reg;
  logic [7:0] match_reg, mask_reg, vector_reg, pulse_ofs_reg, pulse_cnt_reg;
  logic [3:0] addr_mode_reg, int_en_reg, tcnt_reg;
  logic [DW-1:0] data_reg;
  logic [1:0] cause_reg;
  logic [2:0] req_hist_reg;
  logic enabled_reg, eob_reg, match_flag_reg, match_prev_reg, int_pend_reg;
  logic bus_req_reg, ack_reg;
  state_t state_reg, state_next;

  // ==========================================================
  // Bus decode
  logic wb_wr, cmd_wr, ctrl_wr, lo_en, hi_en;
  logic [7:0] cmd;
  // Writes land at the edge where the master samples ack high
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  assign lo_en = wb_wr & wb_sel_i[0];
  assign hi_en = wb_wr & wb_sel_i[1];
  assign cmd = wb_dat_i[7:0];
  assign cmd_wr = lo_en && wb_adr_i == `OFS_COMMAND;
  // Every writable offset counts as a control write
  assign ctrl_wr = wb_wr && (wb_adr_i <= `OFS_COMMAND) &&
                   (wb_adr_i[1:0] == 2'b00);

  // ==========================================================
  // Mode decode
  op_class_t op_class;
  op_mode_t op_mode;
  logic a_is_src, phase_a, ready_act, searching, writing;
  assign op_class = op_class_t'(ctrl_reg[`CTRL_CLASS_LO +: 2]);
  assign op_mode = op_mode_t'(ctrl_reg[`CTRL_MODE_LO +: 2]);
  assign a_is_src = ctrl_reg[`CTRL_A_IS_SRC];
  // Polarity bit flips the sense of the ready pin
  assign ready_act = ready_s ~^ ctrl_reg[`CTRL_RDY_HIGH];
  assign searching = op_class != CLS_TRANSFER;
  assign writing = op_class != CLS_SEARCH;
  // Reads address the source, writes the destination
  assign phase_a = (state_reg == ST_READ) ? a_is_src : ~a_is_src;

  // ==========================================================
  // Cycle length per port, in clocks
  logic [1:0] len_sel;
  logic [3:0] last_clk, early;
  logic port_io, wait_hold, phase_done, in_phase;
  assign len_sel = phase_a ? timing_reg[1:0] : timing_reg[3:2];
  // Codes 0/1/2 give 2/3/4 T-cycles, code 3 also 4
  assign last_clk = 4'((len_sel == 2'd3 ? 3'd4 : 3'(len_sel) + 3'd2)
                    * `CLK_PER_T - 1);
  assign early = phase_a ? timing_reg[7:4] : timing_reg[11:8];
  assign port_io = phase_a ? ctrl_reg[`CTRL_A_IS_IO]
                           : ctrl_reg[`CTRL_B_IS_IO];
  assign in_phase = state_reg == ST_READ || state_reg == ST_WRITE;
  // Slow port stretches the cycle just before its last clock
  assign wait_hold = ctrl_reg[`CTRL_WAIT_EN] & ~wait_n_s &
                     (tcnt_reg == last_clk - 4'd1);
  assign phase_done = in_phase && tcnt_reg == last_clk;

  // ==========================================================
  // Byte compare and end of block
  logic hit, eob_now, other_req, master;
  byte_match #(.WIDTH(DW)) u_match (
    .data(data_reg),
    .match(match_reg[DW-1:0]),
    .mask(mask_reg[DW-1:0]),
    .hit(hit)
  );
  // Count holds finished bytes minus one, so N-1 marks the last
  assign eob_now = count_reg == block_len_reg;
  // Our own request echoes back late, so ignore it for a while
  assign other_req = ~bus_request_line_s & ~bus_req_reg & ~|req_hist_reg;
  assign master = bus_req_reg & ~grant_n_s;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // A grant left over from the last hold must clear first
        if (enabled_reg && ready_act && !other_req && !eob_reg &&
            grant_n_s) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!enabled_reg) begin
          state_next = ST_IDLE;
        end else if (!grant_n_s) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        // Once read, the byte runs to its end regardless of ready
        if (phase_done) begin
          state_next = writing ? ST_WRITE : ST_NEXT;
        end
      end
      ST_WRITE: begin
        if (phase_done) begin
          state_next = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (eob_now) begin
          state_next = ST_RELEASE;
        end else begin
          case (op_mode)
            MODE_BYTE: state_next = ST_RELEASE;
            MODE_BURST: state_next = ready_act ? ST_READ : ST_RELEASE;
            MODE_CONT: state_next = ready_act ? ST_READ : ST_PAUSE;
            default: state_next = ST_RELEASE;
          endcase
        end
      end
      ST_PAUSE: begin
        // Buses stay held while waiting for ready
        if (ready_act) begin
          state_next = ST_READ;
        end
      end
      ST_RELEASE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Phase clock counter, held during wait states
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tcnt_reg <= 4'h0;
    end else if (!in_phase || phase_done) begin
      tcnt_reg <= 4'h0;
    end else if (!wait_hold) begin
      tcnt_reg <= tcnt_reg + 4'h1;
    end
  end

  // Bus request and its echo history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_req_reg <= 1'b0;
      req_hist_reg <= 3'h0;
    end else begin
      bus_req_reg <= state_next != ST_IDLE && state_next != ST_RELEASE;
      req_hist_reg <= {req_hist_reg[1:0], bus_req_reg};
    end
  end

  // ==========================================================
  // Software configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `CTRL_RESET;
      timing_reg <= 12'h000;
      start_a_reg <= '0;
      start_b_reg <= '0;
      block_len_reg <= 16'h0001;
      match_reg <= 8'h00;
      mask_reg <= 8'h00;
      addr_mode_reg <= 4'h5;
      int_en_reg <= 4'h0;
      vector_reg <= `VECTOR_RESET;
      pulse_ofs_reg <= 8'h00;
    end else begin
      if (lo_en) begin
        case (wb_adr_i)
          `OFS_CTRL: ctrl_reg[7:0] <= wb_dat_i[7:0];
          `OFS_TIMING: timing_reg[7:0] <= wb_dat_i[7:0];
          `OFS_START_A: start_a_reg[7:0] <= wb_dat_i[7:0];
          `OFS_START_B: start_b_reg[7:0] <= wb_dat_i[7:0];
          `OFS_BLOCK_LEN: block_len_reg[7:0] <= wb_dat_i[7:0];
          `OFS_MATCH: match_reg <= wb_dat_i[7:0];
          `OFS_ADDR_MODE: addr_mode_reg <= wb_dat_i[3:0];
          `OFS_INT_EN: int_en_reg <= wb_dat_i[3:0];
          `OFS_VECTOR: vector_reg <= wb_dat_i[7:0];
          `OFS_PULSE_OFS: pulse_ofs_reg <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      if (hi_en) begin
        case (wb_adr_i)
          `OFS_CTRL: ctrl_reg[11:8] <= wb_dat_i[11:8];
          `OFS_TIMING: timing_reg[11:8] <= wb_dat_i[11:8];
          `OFS_START_A: start_a_reg[15:8] <= wb_dat_i[15:8];
          `OFS_START_B: start_b_reg[15:8] <= wb_dat_i[15:8];
          `OFS_BLOCK_LEN: block_len_reg[15:8] <= wb_dat_i[15:8];
          `OFS_MATCH: mask_reg <= wb_dat_i[15:8];
          default: ;
        endcase
      end
    end
  end

  // Enable: only the enable command sets it, other control writes clear it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enabled_reg <= 1'b0;
    end else if (cmd_wr && cmd == `CMD_ENABLE) begin
      enabled_reg <= 1'b1;
    end else if (cmd_wr && (cmd == `CMD_READ_STATUS ||
                            cmd == `CMD_INIT_READ)) begin
      enabled_reg <= 1'b0;
    end else if (ctrl_wr) begin
      enabled_reg <= 1'b0;
    end else if (state_reg == ST_NEXT && eob_now &&
                 !ctrl_reg[`CTRL_AUTO_RST]) begin
      enabled_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Address and byte counters
  function automatic logic [AW-1:0] step(input logic [AW-1:0] a,
                                         input logic [1:0] rule);
    case (addr_rule_t'(rule))
      ADR_INC: step = a + AW'(1);
      ADR_DEC: step = a - AW'(1);
      default: step = a;
    endcase
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_a_reg <= '0;
      cur_b_reg <= '0;
      count_reg <= 16'h0000;
    end else if (cmd_wr && cmd == `CMD_LOAD) begin
      cur_a_reg <= start_a_reg;
      cur_b_reg <= start_b_reg;
      count_reg <= 16'h0000;
    end else if (cmd_wr && cmd == `CMD_CONTINUE) begin
      count_reg <= 16'h0000;
    end else if (state_reg == ST_NEXT) begin
      if (eob_now && ctrl_reg[`CTRL_AUTO_RST]) begin
        cur_a_reg <= start_a_reg;
        cur_b_reg <= start_b_reg;
        count_reg <= 16'h0000;
      end else begin
        cur_a_reg <= step(cur_a_reg, addr_mode_reg[1:0]);
        cur_b_reg <= step(cur_b_reg, addr_mode_reg[3:2]);
        if (!eob_now) begin
          count_reg <= count_reg + 16'h0001;
        end
      end
    end
  end

  // Read data latched at the close of the read cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_reg <= '0;
    end else if (state_reg == ST_READ && phase_done) begin
      data_reg <= data_s;
    end
  end

  // ==========================================================
  // Status flags and interrupt; a set in the clear cycle wins
  logic ev_ready, ev_match, ev_eob, ev_both, any_ev, clr_st;
  logic [1:0] cause_now;
  assign ev_ready = state_reg == ST_IDLE && state_next == ST_REQ &&
                    int_en_reg[`IEN_READY];
  assign ev_match = state_reg == ST_NEXT && searching && hit &&
                    int_en_reg[`IEN_MATCH];
  assign ev_eob = state_reg == ST_NEXT && eob_now &&
                  int_en_reg[`IEN_EOB];
  // Read-ahead means the final match belongs to the byte before last
  assign ev_both = state_reg == ST_NEXT && eob_now && match_prev_reg &&
                   int_en_reg[`IEN_MATCH_EOB];
  assign any_ev = ev_ready | ev_match | ev_eob | ev_both;
  assign cause_now = ev_both ? 2'd3 : ev_eob ? 2'd2 : ev_match ? 2'd1 : 2'd0;
  assign clr_st = cmd_wr && (cmd == `CMD_CLR_STATUS ||
                             cmd == `CMD_CONTINUE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eob_reg <= 1'b0;
      match_flag_reg <= 1'b0;
      match_prev_reg <= 1'b0;
      int_pend_reg <= 1'b0;
      cause_reg <= 2'd0;
    end else begin
      if (state_reg == ST_NEXT && eob_now) begin
        eob_reg <= 1'b1;
      end else if (clr_st || (cmd_wr && cmd == `CMD_LOAD)) begin
        eob_reg <= 1'b0;
      end
      if (state_reg == ST_NEXT && searching && hit) begin
        match_flag_reg <= 1'b1;
      end else if (clr_st) begin
        match_flag_reg <= 1'b0;
      end
      if (state_reg == ST_NEXT) begin
        match_prev_reg <= searching & hit;
      end
      if (any_ev) begin
        int_pend_reg <= 1'b1;
        cause_reg <= cause_now;
      end else if (clr_st) begin
        int_pend_reg <= 1'b0;
      end
    end
  end

  // Cause bits replace vector bits 2:1 when so programmed
  logic [7:0] vec_mod;
  assign vec_mod = ctrl_reg[`CTRL_VEC_MOD] ?
                   {vector_reg[7:3], cause_reg, vector_reg[0]}
                   : vector_reg;

  // ==========================================================
  // Pulse counter, wraps every 256 bytes
  logic pulse_evt;
  assign pulse_evt = state_reg == ST_NEXT && ctrl_reg[`CTRL_PULSE_EN] &&
                     pulse_cnt_reg == 8'hFF;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulse_cnt_reg <= 8'h00;
    end else if (cmd_wr && cmd == `CMD_LOAD) begin
      pulse_cnt_reg <= pulse_ofs_reg;
    end else if (state_reg == ST_NEXT) begin
      pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
    end
  end

  // ==========================================================
  // System bus outputs, all registered
  logic strobe_on;
  assign strobe_on = in_phase && (tcnt_reg != last_clk);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_out <= '0;
      addr_oe_n <= 1'b1;
      data_out <= '0;
      data_oe_n <= 1'b1;
      io_request_strobe_n <= 1'b1;
      memory_request_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      addr_out <= phase_a ? cur_a_reg : cur_b_reg;
      addr_oe_n <= ~(master && state_reg != ST_REQ);
      // Early bit cuts the strobe one clock, half a T-cycle, short
      io_request_strobe_n <= ~(in_phase && port_io &&
                               (strobe_on || !early[0]));
      memory_request_strobe_n <= ~(in_phase && !port_io &&
                                   (strobe_on || !early[1]));
      read_strobe_n <= ~(state_reg == ST_READ &&
                         (strobe_on || !early[2]));
      write_strobe_n <= ~(state_reg == ST_WRITE &&
                          (strobe_on || !early[3]));
      if (!bus_req_reg && !intack_n_s && int_pend_reg) begin
        data_out <= vec_mod[DW-1:0];
        data_oe_n <= 1'b0;
      end else begin
        data_out <= data_reg;
        data_oe_n <= state_reg != ST_WRITE;
      end
    end
  end

  // Open-drain pins: value always low, enable decides
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_request_out <= 1'b0;
      interrupt_pulse_out <= 1'b0;
      bus_request_oe_n <= 1'b1;
      interrupt_pulse_oe_n <= 1'b1;
    end else begin
      bus_request_out <= 1'b0;
      interrupt_pulse_out <= 1'b0;
      bus_request_oe_n <= ~bus_req_reg;
      // Pulse only when the processor cannot take it as interrupt
      interrupt_pulse_oe_n <= ~((int_pend_reg && !bus_req_reg) ||
                                (pulse_evt && master));
    end
  end

  // ==========================================================
  // Wishbone answer: ack one cycle after request, reads registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      case (wb_adr_i)
        `OFS_CTRL: wb_dat_o <= {20'h0, ctrl_reg};
        `OFS_TIMING: wb_dat_o <= {20'h0, timing_reg};
        `OFS_START_A: wb_dat_o <= {16'h0, start_a_reg};
        `OFS_START_B: wb_dat_o <= {16'h0, start_b_reg};
        `OFS_BLOCK_LEN: wb_dat_o <= {16'h0, block_len_reg};
        `OFS_MATCH: wb_dat_o <= {16'h0, mask_reg, match_reg};
        `OFS_ADDR_MODE: wb_dat_o <= {28'h0, addr_mode_reg};
        `OFS_INT_EN: wb_dat_o <= {28'h0, int_en_reg};
        `OFS_VECTOR: wb_dat_o <= {24'h0, vector_reg};
        `OFS_PULSE_OFS: wb_dat_o <= {24'h0, pulse_ofs_reg};
        `OFS_STATUS: wb_dat_o <= {24'h0, cause_reg, master, enabled_reg,
                                  int_pend_reg, match_flag_reg, eob_reg,
                                  ready_act};
        `OFS_COUNT: wb_dat_o <= {16'h0, count_reg};
        `OFS_CUR_A: wb_dat_o <= {16'h0, cur_a_reg};
        `OFS_CUR_B: wb_dat_o <= {16'h0, cur_b_reg};
        `OFS_CUR_VEC: wb_dat_o <= {24'h0, vec_mod};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_ack_o = ack_reg;

endmodule

/* tb/dma_sva.sv */
// Port-level assertions for the transfer engine
`timescale 1ns/10ps
module dma_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic bus_request_oe_n,
  input wire logic addr_oe_n,
  input wire logic data_oe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Register bus handshake
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> !wb_dat_o[31:16])
    else $error("upper read bits set");
  // ==========================================================
  // System bus ownership
  AST_STROBE_ADDR: assert property (
    !(read_strobe_n && write_strobe_n) |-> !addr_oe_n)
    else $error("strobe without address");
  AST_RD_NO_DRIVE: assert property (!read_strobe_n |-> data_oe_n)
    else $error("data driven during read");
  AST_ONE_DIR: assert property (read_strobe_n || write_strobe_n)
    else $error("read and write together");
  AST_OWN_BUS: assert property ($fell(addr_oe_n) |-> !bus_request_oe_n)
    else $error("bus taken without request");
  AST_FINISH: assert property (
    $rose(bus_request_oe_n) |-> read_strobe_n && write_strobe_n)
    else $error("released mid byte");
endmodule

/* tb/host_model.sv */
// Host side: grants the bus and serves memory reads
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  input wire logic req_oe_n,
  input wire logic rd_n,
  input wire logic [15:0] addr,
  input wire logic [3:0] dly,
  output logic grant_n,
  output logic [7:0] din
);
  logic [3:0] cnt = 4'h0;
  initial grant_n = 1'b1;
  logic [7:0] junk = 8'h00;
  // Grant after the request stood dly cycles, drop it with the request
  always @(posedge clk) begin
    cnt <= req_oe_n ? 4'h0 : cnt + 4'(cnt != dly);
    grant_n <= req_oe_n || cnt != dly;
  end
  // Junk that flips each cycle when nobody reads, so stale data shows
  always @(posedge clk) junk <= ~junk;
  // Memory answers straight from the address while read is low
  assign din = !rd_n ? addr[7:0] ^ addr[15:8] : junk;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the transfer engine
`timescale 1ns/10ps
`include "dma_defs.svh"
module testbench;
  logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, rdy = 1;
  logic wt = 1, iak = 1;
  logic [7:0] adr = 8'h00, din, dout;
  logic [31:0] dat = 0, q, rdat;
  logic [23:0] exp_q[$];
  int n_fail = 0, samples_checked = 0, seed = 17979, k, m;
  logic [15:0] sa, sb, ao;
  logic [3:0] dly = 4'h0;
  logic ack, bro, boe, gnt, doe, aoe, rd, wr, wr_d, ipo, ipe, io_request_strobe, mrq;
  wire logic breq = boe ? 1'b1 : bro; // Pull-up on the shared request
  always #50 clk = ~clk;
  dma_engine dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bus_request_in(breq), .bus_request_out(bro), .bus_request_oe_n(boe),
    .bus_grant_in_n(gnt), .ready_in(rdy), .chip_select_wait_n(wt),
    .int_ack_n(iak), .data_in(din), .data_out(dout), .data_oe_n(doe),
    .addr_out(ao), .addr_oe_n(aoe), .io_request_strobe_n(io_request_strobe),
    .memory_request_strobe_n(mrq), .read_strobe_n(rd),
    .write_strobe_n(wr), .interrupt_pulse_out(ipo),
    .interrupt_pulse_oe_n(ipe));
  host_model host (.clk(clk), .req_oe_n(boe), .rd_n(rd), .addr(ao),
    .dly(dly), .grant_n(gnt), .din(din));
  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (e !== g) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // Classic single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 32'(d)};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watcher: each falling write strobe retires the oldest note
  always @(posedge clk) begin
    wr_d <= wr;
    if (wr_d === 1'b1 && wr === 1'b0) begin
      chk("bus", exp_q.size() ? exp_q.pop_front() : 'x, {ao, dout});
      chk("strobes", 3'b100, {io_request_strobe, mrq, doe});
    end
  end
  // Slow memory in the last mode asserts wait at random
  always @(posedge clk) wt <= m != 2 || ($random(seed) & 1);
  initial begin
    #(60000 * 100);
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    wb(0, `OFS_CTRL, 0); chk("ctrl", 32'h10, q);
    wb(0, `OFS_STATUS, 0); chk("status", 0, q[4:3]);
    wb(0, `OFS_ADDR_MODE, 0); chk("amode", 5, q);
    wb(0, 8'hFC, 0); chk("unmapped", 0, q);
    // Any control write, status command or read sequence disables
    for (k = 0; k < 3; k++) begin
      wb(1, `OFS_COMMAND, `CMD_ENABLE);
      wb(0, `OFS_STATUS, 0); chk("en_set", 1, q[4]);
      wb(1, k ? `OFS_COMMAND : `OFS_MATCH, k == 1 ? 8'hBF : 8'hA7);
      wb(0, `OFS_STATUS, 0); chk("enabled", 0, q[4]);
    end
    // One 3-byte block per mode, cycle length code follows the mode
    for (m = 0; m < 3; m++) begin
      {sa, sb} = $random(seed);
      dly <= 4'($random(seed) & 7);
      wb(1, `OFS_COMMAND, `CMD_CLR_STATUS);
      // Mode 1 also searches; mode 2 adds waits and vector modify
      wb(1, `OFS_CTRL, 32'h50 | m << 2 | (m & 1) << 1 |
         (m & 2) * 32'h140);
      wb(1, `OFS_TIMING, m | m << 2);
      wb(1, `OFS_START_A, sa);
      wb(1, `OFS_START_B, sb);
      wb(1, `OFS_MATCH, 8'(sa) ^ 8'(sa >> 8));
      wb(1, `OFS_INT_EN, m & 2 ? 4 : 0);
      wb(1, `OFS_VECTOR, 8'h41);
      wb(1, `OFS_BLOCK_LEN, 2);
      wb(1, `OFS_ADDR_MODE, 9);
      for (k = 0; k < 3; k++) exp_q.push_back({sb - 16'(k),
        8'(sa + k) ^ 8'((sa + k) >> 8)});
      wb(1, `OFS_COMMAND, `CMD_LOAD);
      wb(1, `OFS_COMMAND, `CMD_ENABLE);
      rdy <= 1'b1;
      q = 0;
      for (k = 0; k < 300 && !q[1]; k++) wb(0, `OFS_STATUS, 0);
      rdy <= 1'b0;
      chk("eob", m == 2 ? 5 : m == 1 ? 3 : 1, q[4:1]);
      wb(0, `OFS_CUR_A, 0); chk("cur_a", 16'(sa + 16'd3), q);
      chk("left", 0, exp_q.size());
    end
    // Pending end-of-block interrupt: line low, vector on acknowledge
    chk("int_line", 2'b00, {ipe, ipo});
    iak <= 1'b0;
    repeat (4) @(posedge clk);
    chk("vector", 9'h045, {doe, dout});
    iak <= 1'b1;
    wrap_up;
  end
endmodule
bind dma_engine dma_sva sva_i (.clk(clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .bus_request_oe_n(bus_request_oe_n),
  .addr_oe_n(addr_oe_n), .data_oe_n(data_oe_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));
